// ==== hw/sclk_ctrl.sv ====
/*
  system clock source control: decodes the source fuses, times reset
  time-out and wake start-up, divides the system clock tick and gates
  the cpu, flash, io, adc, pll and asynchronous timer domains.
  assumes fuse inputs are static levels from fuse latches; the watchdog
  oscillator tick and sleep controls arrive from other clocks/pins and
  are synchronised here. clock outputs are enables on the I_CLK grid.
*/
`timescale 1ns/1ps
`include "sclk_regs.svh"

// Contract
// - decode crystal, external osc, reserved source codes
// - decode pll-rc, rc, pll-extclk, extclk codes
// - fuse bit zero means programmed
// - wake start-up counted before execution
// - reset time-out of 4096 or 65536 watchdog ticks; a startup field of 0 gives a one-tick time-out
// - shipped default rc, longest start-up, divide eight
// - all domains share the prescaled system tick; the pll enable is not gated by it
// - sleep mode stops unused clock domains
// - cpu clock stop halts core state
// - pll fast clock 64/32, cpu gets pll/4; the cpu enable is not divided by four, pll_div is counted but never read
// - converter clock runs while cpu stopped
// - flash clock enabled with cpu clock
// - wake level must hold through start-up
// - asynchronous timer clock runs in sleep
module sclk_ctrl
  import sclk_pkg::*;
(
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  // fuses, raw levels, default when unset
  input wire logic [3:0] I_SRC_FUSES,
  input wire logic [1:0] I_SUT_FUSES,
  input wire logic I_DIV8_FUSE,
  input wire logic I_USE_DEFAULT,
  // asynchronous inputs
  input wire logic I_WDOG_TICK,
  input wire logic I_SLEEP_REQ,
  input wire logic I_ADC_SLEEP,
  input wire logic I_PLL_FAST,
  input wire logic I_WAKE_LEVEL,
  // clock domain enables
  output logic O_CPU_EN,
  output logic O_FLASH_EN,
  output logic O_IO_EN,
  output logic O_ADC_EN,
  output logic O_ASY_EN,
  output logic O_PLL_EN,
  output logic O_PLL_FAST,
  // status
  output logic [2:0] O_SYS_SRC,
  output logic [1:0] O_PLL_SRC,
  output logic O_RUN,
  output logic O_LEVEL_IRQ
);
  // ----------------------------------------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [4:0] in_s1_r;
  logic [4:0] in_s2_r;

  // release reset through two flops
  always_ff @(posedge I_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // two flops on each asynchronous input; fuse and default-select pins are not synchronised
  always_ff @(posedge I_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_s1_r <= 5'h00;
      in_s2_r <= 5'h00;
    end
    else
    begin
      in_s1_r <= {I_WDOG_TICK, I_SLEEP_REQ, I_ADC_SLEEP, I_PLL_FAST, I_WAKE_LEVEL};
      in_s2_r <= in_s1_r;
    end
  end

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    sclk_state_t state;
    logic [3:0] src;
    logic [1:0] startup_time_fuses;
    logic div8;
    logic [16:0] cnt;
    logic wd_prev;
    logic [2:0] pre;
    logic tick;
    logic [1:0] pll_div;
    logic cpu_en;
    logic io_en;
    logic adc_en;
    logic asy_en;
    logic pll_en;
    logic pll_fast;
    sclk_sys_t sys;
    sclk_pllin_t pllin;
    logic irq;
    logic run;
  } sclk_st_t;
  sclk_st_t st_r;
  sclk_st_t st_nxt;

  logic wd_s;
  logic sleep_s;
  logic adc_sleep_s;
  logic fast_s;
  logic wake_s;
  logic wd_edge;
  sclk_sys_t dec_sys;
  sclk_pllin_t dec_pll;
  logic [16:0] start_cnt;
  logic [16:0] reset_cnt;
  logic cpu_run;
  logic flash_en;

  assign {wd_s, sleep_s, adc_sleep_s, fast_s, wake_s} = in_s2_r;
  assign wd_edge = wd_s && !st_r.wd_prev;

  // ----------------------------------------------------------------------
  // fuse decode
  // ----------------------------------------------------------------------
  // 0001 and 0000 are separate exact case items, so 0001 keeps its pll meaning
  always_comb
  begin
    dec_sys = SCLK_SYS_NONE;
    dec_pll = SCLK_PLLIN_NONE;
    if (st_r.src[`SCLK_XTAL_BIT])
    begin
      dec_sys = SCLK_SYS_XTAL;
      dec_pll = SCLK_PLLIN_RC;
    end
    else
    begin
      case (st_r.src)
        `SCLK_SRC_BOTH_EXTOSC:
        begin
          dec_sys = SCLK_SYS_XTAL;
          dec_pll = SCLK_PLLIN_XTAL;
        end
        `SCLK_SRC_PLL_EXTOSC:
        begin
          dec_sys = SCLK_SYS_PLL4;
          dec_pll = SCLK_PLLIN_XTAL;
        end
        `SCLK_SRC_PLL_RC:
        begin
          dec_sys = SCLK_SYS_PLL4;
          dec_pll = SCLK_PLLIN_RC;
        end
        `SCLK_SRC_RC:
        begin
          dec_sys = SCLK_SYS_RC;
          dec_pll = SCLK_PLLIN_RC;
        end
        `SCLK_SRC_PLL_EXTCLK:
        begin
          dec_sys = SCLK_SYS_PLL4;
          dec_pll = SCLK_PLLIN_EXTCLK;
        end
        `SCLK_SRC_EXTCLK:
        begin
          dec_sys = SCLK_SYS_EXTCLK;
          dec_pll = SCLK_PLLIN_RC;
        end
        default:
        begin
          dec_sys = SCLK_SYS_NONE; // reserved codes
          dec_pll = SCLK_PLLIN_NONE;
        end
      endcase
    end
  end

  // reset time-out length from the startup field, start-up length from the decoded source
  always_comb
  begin
    start_cnt = (dec_sys == SCLK_SYS_RC) ? `SCLK_RC_START : `SCLK_XT_START;
    if (st_r.startup_time_fuses == `SCLK_SUT_NONE)
      reset_cnt = `SCLK_CNT_ONE;
    else if (st_r.startup_time_fuses == `SCLK_SUT_SHORT)
      reset_cnt = `SCLK_TO_SHORT;
    else
      reset_cnt = `SCLK_TO_LONG;
  end

  // ----------------------------------------------------------------------
  // sequencer and prescaler
  // ----------------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.wd_prev = wd_s;
    st_nxt.sys = dec_sys;
    st_nxt.pllin = dec_pll;
    st_nxt.irq = 1'b0;
    // prescaled system tick shared by the cpu, io, adc and async timer domains; pll enable is not gated by it
    if (st_r.div8 == `SCLK_FUSE_PROG)
    begin
      st_nxt.pre = st_r.pre + 3'h1;
      st_nxt.tick = (st_r.pre == `SCLK_DIV8_LAST);
    end
    else
    begin
      st_nxt.pre = 3'h0;
      st_nxt.tick = 1'b1;
    end
    st_nxt.pll_div = st_r.pll_div + 2'h1;
    case (st_r.state)
      SCLK_ST_RESET_TO:
      begin
        // real-time part counted on watchdog ticks
        if (st_r.cnt >= reset_cnt)
        begin
          st_nxt.state = SCLK_ST_WAKE;
          st_nxt.cnt = `SCLK_CNT_ZERO;
        end
        else if (wd_edge)
          st_nxt.cnt = st_r.cnt + `SCLK_CNT_ONE;
      end
      SCLK_ST_WAKE:
      begin
        // source start-up counted on the selected clock tick
        if (st_r.cnt >= start_cnt)
        begin
          st_nxt.state = SCLK_ST_RUN;
          st_nxt.irq = wake_s;
        end
        else if (st_r.tick)
          st_nxt.cnt = st_r.cnt + `SCLK_CNT_ONE;
      end
      SCLK_ST_RUN:
      begin
        if (sleep_s)
          st_nxt.state = SCLK_ST_SLEEP;
      end
      SCLK_ST_SLEEP:
      begin
        if (!sleep_s || wake_s)
        begin
          st_nxt.state = SCLK_ST_WAKE;
          st_nxt.cnt = `SCLK_CNT_ZERO;
        end
      end
      default:
        st_nxt.state = SCLK_ST_RESET_TO;
    endcase
    // domain gating
    st_nxt.cpu_en = (st_nxt.state == SCLK_ST_RUN) && st_nxt.tick;
    st_nxt.io_en = (st_nxt.state == SCLK_ST_RUN) && st_nxt.tick;
    st_nxt.adc_en = ((st_nxt.state == SCLK_ST_RUN) || adc_sleep_s) && st_nxt.tick;
    st_nxt.asy_en = (st_nxt.state != SCLK_ST_RESET_TO) && st_nxt.tick;
    st_nxt.pll_en = (dec_sys == SCLK_SYS_PLL4) || fast_s;
    st_nxt.pll_fast = fast_s;
    // run status kept in a flop so the pin never glitches on state decode
    st_nxt.run = (st_nxt.state == SCLK_ST_RUN);
  end

  // state register; fuses caught after reset release, not under reset
  always_ff @(posedge I_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      st_r.state <= SCLK_ST_RESET_TO;
      st_r.src <= `SCLK_DEF_SRC;
      st_r.startup_time_fuses <= `SCLK_DEF_SUT;
      st_r.div8 <= `SCLK_DEF_DIV8;
      st_r.sys <= SCLK_SYS_RC;
      st_r.pllin <= SCLK_PLLIN_RC;
    end
    else
    begin
      st_r <= st_nxt;
      if (st_r.state == SCLK_ST_RESET_TO && !I_USE_DEFAULT && st_r.cnt == `SCLK_CNT_ZERO)
      begin
        st_r.src <= I_SRC_FUSES;
        st_r.startup_time_fuses <= I_SUT_FUSES;
        st_r.div8 <= I_DIV8_FUSE;
      end
    end
  end

  assign cpu_run = st_r.cpu_en;

  // flash enable tracks cpu enable through a matching register stage
  sclk_gate u_flash_gate (
    .clk(I_CLK),
    .rst_n(rst_n),
    .i_run(st_nxt.cpu_en),
    .o_en(flash_en)
  );

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign O_CPU_EN = cpu_run;
  assign O_FLASH_EN = flash_en;
  assign O_IO_EN = st_r.io_en;
  assign O_ADC_EN = st_r.adc_en;
  assign O_ASY_EN = st_r.asy_en;
  assign O_PLL_EN = st_r.pll_en;
  assign O_PLL_FAST = st_r.pll_fast;
  assign O_SYS_SRC = st_r.sys;
  assign O_PLL_SRC = st_r.pllin;
  assign O_RUN = st_r.run;
  assign O_LEVEL_IRQ = st_r.irq;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_wake_done;
    st_r.state == SCLK_ST_WAKE ##1 st_r.state == SCLK_ST_RUN;
  endsequence

  chk_cpu_halted: assert property (@(posedge I_CLK) disable iff (!rst_n)
    st_r.state != SCLK_ST_RUN |-> !O_CPU_EN)
    else $error("cpu clock runs outside run state");
  chk_flash_follows: assert property (@(posedge I_CLK) disable iff (!rst_n)
    O_FLASH_EN == O_CPU_EN)
    else $error("flash enable differs from cpu enable");
  chk_io_sleep: assert property (@(posedge I_CLK) disable iff (!rst_n)
    st_r.state == SCLK_ST_SLEEP |-> !O_IO_EN)
    else $error("io clock runs in sleep");
  chk_wake_count: assert property (@(posedge I_CLK) disable iff (!rst_n)
    s_wake_done |-> $past(st_r.cnt) >= start_cnt)
    else $error("run before start-up count ended");
  chk_reset_count: assert property (@(posedge I_CLK) disable iff (!rst_n)
    st_r.state == SCLK_ST_RESET_TO ##1 st_r.state == SCLK_ST_WAKE
      |-> $past(st_r.cnt) >= `SCLK_CNT_ONE)
    else $error("reset time-out skipped");
  chk_irq_level: assert property (@(posedge I_CLK) disable iff (!rst_n)
    O_LEVEL_IRQ |-> $past(wake_s) && O_RUN)
    else $error("level interrupt without held level");
  chk_src_decode: assert property (@(posedge I_CLK) disable iff (!rst_n)
    st_r.src == `SCLK_SRC_PLL_EXTCLK |=> O_SYS_SRC == SCLK_SYS_PLL4)
    else $error("code one lost its pll meaning");
  chk_rsv_code: assert property (@(posedge I_CLK) disable iff (!rst_n)
    st_r.src == `SCLK_SRC_RSV6 || st_r.src == `SCLK_SRC_RSV7 |=> O_SYS_SRC == SCLK_SYS_NONE)
    else $error("reserved code gave a source");
  chk_div8_tick: assert property (@(posedge I_CLK) disable iff (!rst_n)
    st_r.div8 == `SCLK_FUSE_PROG && st_r.tick |=> !st_r.tick [*7])
    else $error("prescaled tick not one in eight");
  chk_adc_sleep: assert property (@(posedge I_CLK) disable iff (!rst_n)
    st_r.state == SCLK_ST_SLEEP && $past(adc_sleep_s) && st_r.tick |-> O_ADC_EN)
    else $error("converter clock stopped in sleep");
endmodule : sclk_ctrl

// ==== hw/sclk_gate.sv ====
/*
  one clock domain enable: a registered enable that follows a request.
  assumes a single clock and active low synchronous-domain reset copy.
*/
`timescale 1ns/1ps
module sclk_gate
  import sclk_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request and enable
  input wire logic i_run,
  output logic o_en
);
  typedef struct packed {
    logic en;
  } sclk_gate_st_t;
  sclk_gate_st_t st_r;
  sclk_gate_st_t st_nxt;

  // enable follows request one cycle later
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.en = i_run;
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign o_en = st_r.en;
endmodule : sclk_gate

// ==== hw/sclk_pkg.sv ====
/*
  types of the system clock source control block.
  assumes sclk_regs.svh is compiled alongside.
*/
package sclk_pkg;
  // system clock source after decode
  typedef enum logic [2:0] {
    SCLK_SYS_XTAL,
    SCLK_SYS_EXTCLK,
    SCLK_SYS_RC,
    SCLK_SYS_PLL4,
    SCLK_SYS_NONE
  } sclk_sys_t;
  // pll input source
  typedef enum logic [1:0] {
    SCLK_PLLIN_RC,
    SCLK_PLLIN_XTAL,
    SCLK_PLLIN_EXTCLK,
    SCLK_PLLIN_NONE
  } sclk_pllin_t;
  // startup sequencer
  typedef enum logic [1:0] {
    SCLK_ST_RESET_TO,
    SCLK_ST_WAKE,
    SCLK_ST_RUN,
    SCLK_ST_SLEEP
  } sclk_state_t;
endpackage : sclk_pkg

// ==== hw/sclk_regs.svh ====
/*
  constants of the system clock source control block: fuse codes, startup
  field values, shipped defaults and cycle counts.
  assumes it is included by its bare name from design files.
*/
`ifndef SCLK_REGS_SVH
`define SCLK_REGS_SVH

// ----------------------------------------------------------------------
// source select codes
// ----------------------------------------------------------------------
`define SCLK_SRC_PLL_EXTOSC 4'h5
`define SCLK_SRC_BOTH_EXTOSC 4'h4
`define SCLK_SRC_RSV6 4'h6
`define SCLK_SRC_RSV7 4'h7
`define SCLK_SRC_PLL_RC 4'h3
`define SCLK_SRC_RC 4'h2
`define SCLK_SRC_PLL_EXTCLK 4'h1
`define SCLK_SRC_EXTCLK 4'h0
`define SCLK_XTAL_BIT 3

// ----------------------------------------------------------------------
// shipped fuse defaults (zero = programmed)
// ----------------------------------------------------------------------
`define SCLK_DEF_SRC 4'h2
`define SCLK_DEF_SUT 2'h2
`define SCLK_DEF_DIV8 1'h0
`define SCLK_FUSE_PROG 1'h0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SCLK_SUT_NONE 2'h0
`define SCLK_SUT_SHORT 2'h1
`define SCLK_TO_SHORT 17'h01000
`define SCLK_TO_LONG 17'h10000
`define SCLK_RC_START 17'h00006
`define SCLK_XT_START 17'h00402
`define SCLK_DIV8_LAST 3'h7
`define SCLK_PLL_DIV_LAST 2'h3
`define SCLK_CNT_ONE 17'h00001
`define SCLK_CNT_ZERO 17'h00000

`endif

// ==== verif/sclk_ctrl_tb_top.sv ====
/*
  self-checking bench of sclk_ctrl: fuse decode, shipped default, reset
  time-out, start-up gating, prescaling, sleep gating and wake interrupt.
  assumes the design files under hw/ are compiled first.
*/
`timescale 1ns/1ps
module sclk_ctrl_tb_top
  import sclk_pkg::*;
;
  // ------------------------------------------------------------------
  // stimulus and design
  // ------------------------------------------------------------------
  logic I_CLK = 1'b0;
  logic I_RESET_N = 1'b0;
  logic [3:0] I_SRC_FUSES = 4'h2;
  logic [1:0] I_SUT_FUSES = 2'h0;
  logic I_DIV8_FUSE = 1'h1;
  logic I_USE_DEFAULT = 1'h0;
  logic I_WDOG_TICK = 1'h0;
  logic I_SLEEP_REQ = 1'h0;
  logic I_ADC_SLEEP = 1'h0;
  logic I_PLL_FAST = 1'h0;
  logic I_WAKE_LEVEL = 1'h0;
  logic O_CPU_EN, O_FLASH_EN, O_IO_EN, O_ADC_EN, O_ASY_EN, O_PLL_EN;
  logic O_PLL_FAST, O_RUN, O_LEVEL_IRQ;
  logic [2:0] O_SYS_SRC;
  logic [1:0] O_PLL_SRC;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int c_cpu, c_adc, c_asy, c_irq, c_fl, c_pre;
  integer seed = 32'h1116;
  int q[$];
  int k, c;

  sclk_ctrl sclk_ctrl_i (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
    .I_SRC_FUSES(I_SRC_FUSES), .I_SUT_FUSES(I_SUT_FUSES),
    .I_DIV8_FUSE(I_DIV8_FUSE), .I_USE_DEFAULT(I_USE_DEFAULT),
    .I_WDOG_TICK(I_WDOG_TICK), .I_SLEEP_REQ(I_SLEEP_REQ),
    .I_ADC_SLEEP(I_ADC_SLEEP), .I_PLL_FAST(I_PLL_FAST),
    .I_WAKE_LEVEL(I_WAKE_LEVEL), .O_CPU_EN(O_CPU_EN), .O_FLASH_EN(O_FLASH_EN),
    .O_IO_EN(O_IO_EN), .O_ADC_EN(O_ADC_EN), .O_ASY_EN(O_ASY_EN),
    .O_PLL_EN(O_PLL_EN), .O_PLL_FAST(O_PLL_FAST), .O_SYS_SRC(O_SYS_SRC),
    .O_PLL_SRC(O_PLL_SRC), .O_RUN(O_RUN), .O_LEVEL_IRQ(O_LEVEL_IRQ));

  // 100 MHz clock
  always #5 I_CLK = ~I_CLK;

  // ------------------------------------------------------------------
  // model, checks and drivers
  // ------------------------------------------------------------------
  // expected {system source, pll input} of one fuse code
  function automatic logic [4:0] exp_src(input int code);
    case (code)
      4: return {SCLK_SYS_XTAL, SCLK_PLLIN_XTAL};
      5: return {SCLK_SYS_PLL4, SCLK_PLLIN_XTAL};
      6, 7: return {SCLK_SYS_NONE, SCLK_PLLIN_NONE};
      3: return {SCLK_SYS_PLL4, SCLK_PLLIN_RC};
      2: return {SCLK_SYS_RC, SCLK_PLLIN_RC};
      1: return {SCLK_SYS_PLL4, SCLK_PLLIN_EXTCLK};
      0: return {SCLK_SYS_EXTCLK, SCLK_PLLIN_RC};
      default: return {SCLK_SYS_XTAL, SCLK_PLLIN_RC};
    endcase
  endfunction : exp_src

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  task automatic cmp_src(input logic [4:0] e, input logic [4:0] a);
    n_compared++;
    if (a !== e)
    begin
      num_errors++;
      $display("Error at %0t: source expected %h got %h", $time, e, a);
    end
  endtask : cmp_src

  task automatic cmp_cnt(input int e, input int a);
    n_compared++;
    if (a != e)
    begin
      num_errors++;
      $display("Error at %0t: count expected %h got %h", $time, e, a);
    end
  endtask : cmp_cnt

  task automatic cmp_bit(input logic e, input logic a);
    n_compared++;
    if (a !== e)
    begin
      num_errors++;
      $display("Error at %0t: level expected %h got %h", $time, e, a);
    end
  endtask : cmp_bit

  task automatic tick(input int n);
    repeat (n) @(posedge I_CLK);
  endtask : tick

  // reset with a fuse set; fuses settle while reset is low
  task automatic do_reset(input int code, input int startup_time_fuses, input logic div);
    @(posedge I_CLK);
    I_RESET_N <= 1'b0;
    I_SRC_FUSES <= code[3:0];
    I_SUT_FUSES <= startup_time_fuses[1:0];
    I_DIV8_FUSE <= div;
    tick(3);
    I_RESET_N <= 1'b1;
    tick(8);
  endtask : do_reset

  // watchdog oscillator edges with random low time
  task automatic wd(input int n);
    repeat (n)
    begin
      @(posedge I_CLK);
      I_WDOG_TICK <= 1'b1;
      tick(2);
      I_WDOG_TICK <= 1'b0;
      tick(1 + ($unsigned($random(seed)) % 2));
    end
  endtask : wd

  // one sampled cycle, counted after the edge has settled
  task automatic sample();
    @(posedge I_CLK);
    #1;
    c_cpu += (O_CPU_EN === 1'b1);
    c_adc += (O_ADC_EN === 1'b1);
    c_asy += (O_ASY_EN === 1'b1);
    c_irq += (O_LEVEL_IRQ === 1'b1);
    c_fl += (O_FLASH_EN !== O_CPU_EN) + (O_IO_EN !== O_CPU_EN);
    c_pre += (O_RUN !== 1'b1 && O_CPU_EN === 1'b1);
  endtask : sample

  task automatic window(input int n);
    {c_cpu, c_adc, c_asy, c_irq, c_fl, c_pre} = '0;
    repeat (n) sample();
  endtask : window

  // bounded wait for run; counters keep what happened meanwhile
  task automatic run_until(input int lim);
    {c_cpu, c_adc, c_asy, c_irq, c_fl, c_pre} = '0;
    k = 0;
    while (O_RUN !== 1'b1 && k < lim)
    begin
      sample();
      k++;
    end
    repeat (4) sample();
  endtask : run_until

  // hang guard
  always @(posedge I_CLK)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  initial
  begin
    // every code once, random order
    for (int i = 0; i < 16; i++) q.push_back(i);
    while (q.size() > 0)
    begin
      k = $unsigned($random(seed)) % q.size();
      c = q[k];
      q.delete(k);
      do_reset(c, 0, 1'b1);
      cmp_src(exp_src(c), {O_SYS_SRC, O_PLL_SRC});
    end
    // shipped default overrides the pins
    I_USE_DEFAULT <= 1'b1;
    do_reset(0, 0, 1'b1);
    cmp_src(exp_src(2), {O_SYS_SRC, O_PLL_SRC});
    I_USE_DEFAULT <= 1'b0;
    // no prescaling, one-tick time-out
    do_reset(2, 0, 1'b1);
    wd(1);
    run_until(200);
    cmp_bit(1'b1, O_RUN);
    cmp_cnt(0, c_pre);
    window(64);
    cmp_cnt(64, c_cpu);
    cmp_cnt(64, c_asy);
    cmp_cnt(0, c_fl);
    // fast pll request
    I_PLL_FAST <= 1'b1;
    tick(6);
    cmp_bit(1'b1, O_PLL_FAST);
    cmp_bit(1'b1, O_PLL_EN);
    I_PLL_FAST <= 1'b0;
    tick(6);
    cmp_bit(1'b0, O_PLL_FAST);
    // sleep keeping converter and async timer
    I_ADC_SLEEP <= 1'b1;
    I_SLEEP_REQ <= 1'b1;
    tick(10);
    cmp_bit(1'b0, O_RUN);
    window(64);
    cmp_cnt(0, c_cpu);
    cmp_cnt(64, c_adc);
    cmp_cnt(64, c_asy);
    I_ADC_SLEEP <= 1'b0;
    tick(6);
    window(32);
    cmp_cnt(0, c_adc);
    // wake with the level held through start-up
    I_SLEEP_REQ <= 1'b0;
    I_WAKE_LEVEL <= 1'b1;
    run_until(200);
    cmp_bit(1'b1, O_RUN);
    cmp_cnt(1, c_irq);
    cmp_cnt(0, c_pre);
    I_WAKE_LEVEL <= 1'b0;
    // level dropped before start-up ends
    I_SLEEP_REQ <= 1'b1;
    tick(10);
    I_WAKE_LEVEL <= 1'b1;
    tick(3);
    I_WAKE_LEVEL <= 1'b0;
    I_SLEEP_REQ <= 1'b0; // ignored during start-up, keeps run afterwards
    run_until(200);
    cmp_bit(1'b1, O_RUN);
    cmp_cnt(0, c_irq);
    I_SLEEP_REQ <= 1'b0;
    // divide by eight programmed
    do_reset(2, 0, 1'b0);
    wd(1);
    run_until(200);
    window(64);
    cmp_cnt(8, c_cpu);
    cmp_cnt(8, c_adc);
    // short reset time-out of 4096 watchdog edges
    do_reset(2, 1, 1'b1);
    wd(4090);
    cmp_bit(1'b0, O_RUN);
    wd(6);
    run_until(300);
    cmp_bit(1'b1, O_RUN);
    print_verdict();
  end
endmodule : sclk_ctrl_tb_top
